// [hdl/srxl_regs.sv]
// Purpose: receive link configuration and status registers over APB
// Assumes: eight lanes, lane status synchronous to clk
// Notes: zero wait state APB slave; unmapped reads zero with pslverr
`timescale 1ns/100ps
// Behaviour
// - two-bit subclass select, resets to one
// - ten-bit buffer delay, resets to zero
// - bit 8 disables error reporting on sync
// - bit 0 enables per-lane error counters
// - counters hold while enable is clear
// - sysref captured bit 16 in subclass 1
// - status bit 0 shows link sync
// - debug register, four bits per lane
// - bit3 data start, bit2 ila start
// - bits 3:2 sticky, clear on read
// - bits 1:0 live cgs and k28.5
module srxl_regs
   import srxl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link status from the receiver
   input wire logic sync_ok,
   input wire logic sysref_evt,
   input wire logic [7:0] lane_data_start,
   input wire logic [7:0] lane_ila_start,
   input wire logic [7:0] lane_cgs,
   input wire logic [7:0] lane_k28,
   input wire logic [7:0] lane_link_err,
   input wire logic [79:0] lane_buf_adjust,
   // configuration to the receiver
   output logic [1:0] subclass,
   output logic [9:0] buf_delay,
   output logic sync_err_dis,
   // interrupt
   output logic irq
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] subclass;
      logic [9:0] delay;
      logic sync_dis;
      logic cnt_en;
      logic sync;
      logic sysref_cap;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic irq;
   } srxl_regs_t;
   srxl_regs_t s_r, s_nxt;

   logic [31:0] dbg_word;
   logic [15:0] cnt [SRXL_LANES];
   logic [9:0] adj [SRXL_LANES];
   logic setup, acc_wr, dbg_rd;
   logic [31:0] rd_mux;
   logic rd_bad;

   assign setup = psel && !penable;
   // answer one cycle after setup; access ends with pready high
   assign acc_wr = psel && penable && s_r.ready && pwrite;
   assign dbg_rd = setup && !pwrite && paddr == SRXL_OFF_DEBUG;

   // ---------------------------------------------------------------
   // lanes
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < SRXL_LANES; g++) begin : g_lane
         srxl_lane_dbg u_lane (
            .clk(clk),
            .rstn(rstn),
            .data_start(lane_data_start[g]),
            .ila_start(lane_ila_start[g]),
            .cgs(lane_cgs[g]),
            .k_rx(lane_k28[g]),
            .link_err(lane_link_err[g]),
            .dbg_rd(dbg_rd),
            .cnt_en(s_r.cnt_en),
            .dbg(dbg_word[g*SRXL_DBG_W +: SRXL_DBG_W]),
            .err_cnt(cnt[g])
         );
         assign adj[g] = lane_buf_adjust[g*SRXL_ADJ_W +: SRXL_ADJ_W];
      end
   endgenerate

   // ---------------------------------------------------------------
   // read decode
   // ---------------------------------------------------------------
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_bad = 1'b0;
      if (paddr[1:0] != 2'h0) begin
         rd_bad = 1'b1;
      end else if (paddr == SRXL_OFF_SUBCLASS) begin
         rd_mux[1:0] = s_r.subclass;
      end else if (paddr == SRXL_OFF_BUF_DELAY) begin
         rd_mux[9:0] = s_r.delay;
      end else if (paddr == SRXL_OFF_ERR_CTRL) begin
         rd_mux[SRXL_ERR_SYNC_DIS_BIT] = s_r.sync_dis;
         rd_mux[SRXL_ERR_CNT_EN_BIT] = s_r.cnt_en;
      end else if (paddr == SRXL_OFF_SYNC_STAT) begin
         rd_mux[SRXL_SYSREF_BIT] = s_r.sysref_cap;
         rd_mux[SRXL_SYNC_BIT] = s_r.sync;
      end else if (paddr == SRXL_OFF_DEBUG) begin
         rd_mux = dbg_word;
      end else if (paddr >= SRXL_OFF_ADJ_LO
                   && paddr < SRXL_OFF_ERRCNT_LO) begin
         rd_mux[9:0] = adj[paddr[4:2] - 3'h5];
      end else if (paddr >= SRXL_OFF_ERRCNT_LO
                   && paddr < SRXL_OFF_IRQ_STAT) begin
         rd_mux[15:0] = cnt[paddr[4:2] - 3'h5];
      end else if (paddr == SRXL_OFF_IRQ_STAT) begin
         rd_mux[2:0] = s_r.irq_stat;
      end else if (paddr == SRXL_OFF_IRQ_MASK) begin
         rd_mux[2:0] = s_r.irq_mask;
      end else begin
         rd_bad = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.ready = setup;
      // error flag lives only for the access cycle, like pready
      s_nxt.err = setup && rd_bad;
      if (setup) begin
         s_nxt.rdata = pwrite ? 32'h0000_0000 : rd_mux;
      end
      if (acc_wr && !s_r.err) begin
         if (paddr == SRXL_OFF_SUBCLASS) begin
            s_nxt.subclass = pwdata[1:0];
         end
         if (paddr == SRXL_OFF_BUF_DELAY) begin
            s_nxt.delay = pwdata[9:0];
         end
         if (paddr == SRXL_OFF_ERR_CTRL) begin
            s_nxt.sync_dis = pwdata[SRXL_ERR_SYNC_DIS_BIT];
            s_nxt.cnt_en = pwdata[SRXL_ERR_CNT_EN_BIT];
         end
         if (paddr == SRXL_OFF_IRQ_STAT) begin
            s_nxt.irq_stat = s_r.irq_stat & ~pwdata[2:0];
         end
         if (paddr == SRXL_OFF_IRQ_MASK) begin
            s_nxt.irq_mask = pwdata[2:0];
         end
      end
      s_nxt.sync = sync_ok;
      if (sysref_evt && s_r.subclass == SRXL_SUBCLASS_1) begin
         s_nxt.sysref_cap = 1'b1;
      end
      // events set after the clear so a same-cycle event wins
      if (sync_ok && !s_r.sync) s_nxt.irq_stat[SRXL_IRQ_SYNC] = 1'b1;
      if (!sync_ok && s_r.sync) s_nxt.irq_stat[SRXL_IRQ_LOSS] = 1'b1;
      if (sysref_evt && s_r.subclass == SRXL_SUBCLASS_1) begin
         s_nxt.irq_stat[SRXL_IRQ_SYSREF] = 1'b1;
      end
      s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_r <= '0;
         s_r.subclass <= SRXL_SUBCLASS_RST;
         s_r.delay <= SRXL_DELAY_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.rdata;
   assign pready = s_r.ready;
   assign pslverr = s_r.err;
   assign subclass = s_r.subclass;
   assign buf_delay = s_r.delay;
   assign sync_err_dis = s_r.sync_dis;
   assign irq = s_r.irq;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_wr_sub;
      psel && penable && pready && pwrite && !pslverr
         && paddr == SRXL_OFF_SUBCLASS;
   endsequence
   property p_sub_wr;
      @(posedge clk) disable iff (!rstn)
         s_wr_sub |=> subclass == $past(pwdata[1:0]);
   endproperty
   a_sub_wr: assert property (p_sub_wr)
      else $error("subclass write not stored");

   property p_delay_wr;
      @(posedge clk) disable iff (!rstn)
         (psel && penable && pready && pwrite
          && paddr == SRXL_OFF_BUF_DELAY)
         |=> buf_delay == $past(pwdata[9:0]);
   endproperty
   a_delay_wr: assert property (p_delay_wr)
      else $error("buffer delay write not stored");

   property p_sync_rd;
      @(posedge clk) disable iff (!rstn)
         (setup && !pwrite && paddr == SRXL_OFF_SYNC_STAT)
         |=> prdata[SRXL_SYNC_BIT] == $past(s_r.sync)
             && prdata[31:17] == 15'h0000 && prdata[15:1] == 15'h0000;
   endproperty
   a_sync_rd: assert property (p_sync_rd)
      else $error("sync status read wrong");

   property p_sysref;
      @(posedge clk) disable iff (!rstn)
         (sysref_evt && subclass == SRXL_SUBCLASS_1)
         |=> s_r.sysref_cap [*2];
   endproperty
   a_sysref: assert property (p_sysref)
      else $error("sysref capture not held");

   property p_sub_rd;
      @(posedge clk) disable iff (!rstn)
         (setup && !pwrite && paddr == SRXL_OFF_SUBCLASS)
         |=> prdata[31:2] == 30'h0 && pready;
   endproperty
   a_sub_rd: assert property (p_sub_rd)
      else $error("reserved subclass bits not zero");

   property p_dis_wr;
      @(posedge clk) disable iff (!rstn)
         (psel && penable && pready && pwrite
          && paddr == SRXL_OFF_ERR_CTRL)
         |=> sync_err_dis == $past(pwdata[SRXL_ERR_SYNC_DIS_BIT]);
   endproperty
   a_dis_wr: assert property (p_dis_wr)
      else $error("sync error disable not stored");

   sequence s_rd_dbg;
      setup && !pwrite && paddr == SRXL_OFF_DEBUG;
   endsequence
   property p_dbg_live;
      @(posedge clk) disable iff (!rstn)
         s_rd_dbg |=> prdata[1] == $past(lane_cgs[0])
                      && prdata[0] == $past(lane_k28[0]);
   endproperty
   a_dbg_live: assert property (p_dbg_live)
      else $error("lane 0 live debug bits wrong");

   property p_dbg_clr;
      @(posedge clk) disable iff (!rstn)
         s_rd_dbg ##0 !lane_data_start[0] |=> !dbg_word[SRXL_DBG_DATA_BIT];
   endproperty
   a_dbg_clr: assert property (p_dbg_clr)
      else $error("lane 0 data start flag not cleared by read");

   sequence s_wr_err;
      psel && penable && pready && pwrite && paddr == SRXL_OFF_ERR_CTRL;
   endsequence
   property p_cnt_en_wr;
      @(posedge clk) disable iff (!rstn)
         s_wr_err |=> s_r.cnt_en == $past(pwdata[SRXL_ERR_CNT_EN_BIT]);
   endproperty
   a_cnt_en_wr: assert property (p_cnt_en_wr)
      else $error("counter enable write not stored");

   property p_sysref_sub;
      @(posedge clk) disable iff (!rstn)
         (!s_r.sysref_cap && !(sysref_evt && subclass == SRXL_SUBCLASS_1))
         |=> !s_r.sysref_cap;
   endproperty
   a_sysref_sub: assert property (p_sysref_sub)
      else $error("sysref captured outside subclass 1");

   property p_ready_pulse;
      @(posedge clk) disable iff (!rstn)
         pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("pready held longer than one cycle");

   property p_irq;
      @(posedge clk) disable iff (!rstn)
         irq == |(s_r.irq_stat & s_r.irq_mask);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt level wrong");
endmodule

// [hdl/srxl_pkg.sv]
// Purpose: constants for the receive link status register bank
// Assumes: APB, 32-bit data, word-aligned registers
// Notes: offsets are byte addresses
package srxl_pkg;
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] SRXL_OFF_SUBCLASS = 8'h00;
   localparam logic [7:0] SRXL_OFF_BUF_DELAY = 8'h04;
   localparam logic [7:0] SRXL_OFF_ERR_CTRL = 8'h08;
   localparam logic [7:0] SRXL_OFF_SYNC_STAT = 8'h0c;
   localparam logic [7:0] SRXL_OFF_DEBUG = 8'h10;
   localparam logic [7:0] SRXL_OFF_ADJ_LO = 8'h14;
   localparam logic [7:0] SRXL_OFF_ERRCNT_LO = 8'h34;
   localparam logic [7:0] SRXL_OFF_IRQ_STAT = 8'h54;
   localparam logic [7:0] SRXL_OFF_IRQ_MASK = 8'h58;
   // ---------------------------------------------------------------
   // fields and resets
   // ---------------------------------------------------------------
   localparam int SRXL_LANES = 8;
   localparam int SRXL_SUBCLASS_W = 2;
   localparam int SRXL_DELAY_W = 10;
   localparam int SRXL_ADJ_W = 10;
   localparam int SRXL_CNT_W = 16;
   localparam int SRXL_ERR_SYNC_DIS_BIT = 8;
   localparam int SRXL_ERR_CNT_EN_BIT = 0;
   localparam int SRXL_SYSREF_BIT = 16;
   localparam int SRXL_SYNC_BIT = 0;
   localparam int SRXL_DBG_W = 4;
   localparam int SRXL_DBG_DATA_BIT = 3;
   localparam int SRXL_DBG_ILA_BIT = 2;
   localparam int SRXL_DBG_CGS_BIT = 1;
   localparam int SRXL_DBG_K_BIT = 0;
   localparam int SRXL_IRQ_W = 3;
   localparam int SRXL_IRQ_SYNC = 0;
   localparam int SRXL_IRQ_SYSREF = 1;
   localparam int SRXL_IRQ_LOSS = 2;
   localparam logic [1:0] SRXL_SUBCLASS_RST = 2'h1;
   localparam logic [1:0] SRXL_SUBCLASS_1 = 2'h1;
   localparam logic [9:0] SRXL_DELAY_RST = 10'h000;
endpackage

// [hdl/srxl_lane_dbg.sv]
// Purpose: one lane's debug nibble and link error counter
// Assumes: lane inputs synchronous to clk
// Notes: sticky bits clear on register read
`timescale 1ns/100ps
module srxl_lane_dbg
   import srxl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // lane status
   input wire logic data_start,
   input wire logic ila_start,
   input wire logic cgs,
   input wire logic k_rx,
   input wire logic link_err,
   // control
   input wire logic dbg_rd,
   input wire logic cnt_en,
   // results
   output logic [3:0] dbg,
   output logic [15:0] err_cnt
);
   typedef struct packed {
      logic data_seen;
      logic ila_seen;
      logic [15:0] cnt;
   } srxl_lane_t;
   srxl_lane_t s_r, s_nxt;

   always_comb begin
      s_nxt = s_r;
      // read clears, but a new event in the same cycle still lands
      if (dbg_rd) begin
         s_nxt.data_seen = 1'b0;
         s_nxt.ila_seen = 1'b0;
      end
      if (data_start) s_nxt.data_seen = 1'b1;
      if (ila_start) s_nxt.ila_seen = 1'b1;
      // saturate at 16'hffff rather than wrap so a long burst never reads back as a small count
      if (cnt_en && link_err && s_r.cnt != 16'hffff) begin
         s_nxt.cnt = s_r.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) s_r <= '0;
      else s_r <= s_nxt;
   end

   assign dbg = {s_r.data_seen, s_r.ila_seen, cgs, k_rx};
   assign err_cnt = s_r.cnt;

   property p_cnt_hold;
      @(posedge clk) disable iff (!rstn)
         !cnt_en |=> $stable(s_r.cnt);
   endproperty
   a_cnt_hold: assert property (p_cnt_hold)
      else $error("error count moved while disabled");

   property p_sticky;
      @(posedge clk) disable iff (!rstn)
         (s_r.data_seen && !dbg_rd) |=> s_r.data_seen;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("data start flag dropped without read");
endmodule

// [bench/srxl_link_model.sv]
// Purpose: far-side link model driving lane status
// Assumes: requests come from the bench on clk
// Notes: every output moves one edge after its request
`timescale 1ns/100ps
module srxl_link_model (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // requests from the bench
   input wire logic sync_req,
   input wire logic sysref_req,
   input wire logic [7:0] ila_req,
   input wire logic [7:0] data_req,
   input wire logic [7:0] err_req,
   input wire logic [7:0] cgs_req,
   input wire logic [7:0] k_req,
   input wire logic [79:0] adj_req,
   // lane status toward the receiver
   output logic sync_ok,
   output logic sysref_evt,
   output logic [7:0] lane_ila_start,
   output logic [7:0] lane_data_start,
   output logic [7:0] lane_link_err,
   output logic [7:0] lane_cgs,
   output logic [7:0] lane_k28,
   output logic [79:0] lane_buf_adjust
);
   // registered so the receiver never sees a same-edge change
   always_ff @(posedge clk) begin
      if (!rstn) begin
         {sync_ok, sysref_evt, lane_ila_start, lane_data_start} <= '0;
         {lane_link_err, lane_cgs, lane_k28, lane_buf_adjust} <= '0;
      end else begin
         sync_ok <= sync_req;
         sysref_evt <= sysref_req;
         lane_ila_start <= ila_req;
         lane_data_start <= data_req;
         lane_link_err <= err_req;
         lane_cgs <= cgs_req;
         lane_k28 <= k_req;
         lane_buf_adjust <= adj_req;
      end
   end
endmodule

// [bench/serial_converter_rx_link_status_regs_tb.sv]
// Purpose: self-checking bench for the link status registers
// Assumes: zero wait APB slave, link model on the far side
// Notes: reads are noted in a queue and checked by a monitor
`timescale 1ns/100ps
module serial_converter_rx_link_status_regs_tb;
   import srxl_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] d; logic e;} srxl_note_t;
   logic clk, rstn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr, ila_req, data_req, err_req, cgs_req, k_req;
   logic [31:0] pwdata, prdata, v, exd;
   logic sync_req, sysref_req, sync_ok, sysref_evt, sync_err_dis;
   logic [7:0] l_ila, l_dat, l_err, l_cgs, l_k;
   logic [79:0] adj_req, l_adj;
   logic [1:0] subclass;
   logic [9:0] buf_delay, mn;
   logic [15:0] cnt [8];
   int err_count, n_compared, cyc, i;
   srxl_note_t q[$];
   // ---------------------------------------------------------------
   // clock, model, design
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   srxl_link_model u_link (.clk(clk), .rstn(rstn), .sync_req(sync_req),
      .sysref_req(sysref_req), .ila_req(ila_req), .data_req(data_req),
      .err_req(err_req), .cgs_req(cgs_req), .k_req(k_req),
      .adj_req(adj_req), .sync_ok(sync_ok), .sysref_evt(sysref_evt),
      .lane_ila_start(l_ila), .lane_data_start(l_dat),
      .lane_link_err(l_err), .lane_cgs(l_cgs), .lane_k28(l_k),
      .lane_buf_adjust(l_adj));
   srxl_regs u_dut (.clk(clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sync_ok(sync_ok), .sysref_evt(sysref_evt), .lane_data_start(l_dat),
      .lane_ila_start(l_ila), .lane_cgs(l_cgs), .lane_k28(l_k),
      .lane_link_err(l_err), .lane_buf_adjust(l_adj),
      .subclass(subclass), .buf_delay(buf_delay),
      .sync_err_dis(sync_err_dis), .irq(irq));
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] ex,
                      input logic [31:0] got);
      n_compared++;
      if (got !== ex) begin
         err_count++;
         $display("[FAIL] %s exp %h got %h", nm, ex, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // request holds until pready is sampled high at a rising edge
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ex,
                     input logic e);
      q.push_back('{a, ex, e});
      apb(1'b0, a, 32'h0);
   endtask
   task automatic ev(input logic [7:0] e, input logic [7:0] il,
                     input logic [7:0] dt, input logic sr);
      @(posedge clk);
      {err_req, ila_req, data_req, sysref_req} <= {e, il, dt, sr};
      @(posedge clk);
      {err_req, ila_req, data_req, sysref_req} <= '0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic results;
      if (err_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // read monitor and watchdog
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1
          && pwrite === 1'b0) begin
         if (q.size() == 0) begin
            err_count++;
            $display("[FAIL] read note exp 1 got 0");
         end else begin
            chk($sformatf("read %h", q[0].a), q[0].d, prdata);
            chk("pslverr", {31'h0, q[0].e}, {31'h0, pslverr});
            void'(q.pop_front());
         end
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
      {sync_req, sysref_req, ila_req, data_req, err_req} = '0;
      {cgs_req, k_req, adj_req, err_count, n_compared, cyc} = '0;
      void'($urandom(32'h07250130));
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      rd(SRXL_OFF_SUBCLASS, 32'h1, 1'b0);
      rd(SRXL_OFF_BUF_DELAY, 32'h0, 1'b0);
      rd(SRXL_OFF_ERR_CTRL, 32'h0, 1'b0);
      rd(SRXL_OFF_SYNC_STAT, 32'h0, 1'b0);
      rd(SRXL_OFF_DEBUG, 32'h0, 1'b0);
      for (i = 0; i < 4; i++) begin
         v = $urandom;
         v[1:0] = 2'(i);
         wr(SRXL_OFF_SUBCLASS, v);
         rd(SRXL_OFF_SUBCLASS, {30'h0, v[1:0]}, 1'b0);
      end
      mn = 10'h3ff;
      for (i = 0; i < 8; i++) begin
         v = $urandom;
         adj_req[i*10 +: 10] <= v[9:0];
         mn = (v[9:0] < mn) ? v[9:0] : mn;
         rd(SRXL_OFF_ADJ_LO + 8'(4*i), {22'h0, v[9:0]}, 1'b0);
      end
      v = $urandom;
      wr(SRXL_OFF_BUF_DELAY, {v[31:10], mn});
      rd(SRXL_OFF_BUF_DELAY, {22'h0, mn}, 1'b0);
      chk("buf_delay", {22'h0, mn}, {22'h0, buf_delay});
      wr(SRXL_OFF_ERR_CTRL, 32'h100);
      settle(1);
      chk("sync_err_dis", 32'h1, {31'h0, sync_err_dis});
      ev(8'hff, 8'h0, 8'h0, 1'b0);
      rd(SRXL_OFF_ERRCNT_LO + 8'h1c, 32'h0, 1'b0);
      wr(SRXL_OFF_ERR_CTRL, 32'hfffffeff);
      rd(SRXL_OFF_ERR_CTRL, 32'h1, 1'b0);
      chk("sync_err_dis", 32'h0, {31'h0, sync_err_dis});
      for (i = 0; i < 8; i++) cnt[i] = 16'h0;
      repeat (3) begin
         v = $urandom;
         ev(v[7:0], 8'h0, 8'h0, 1'b0);
         for (i = 0; i < 8; i++) cnt[i] += 16'(v[i]);
      end
      for (i = 0; i < 8; i++) begin
         rd(SRXL_OFF_ERRCNT_LO + 8'(4*i), {16'h0, cnt[i]}, 1'b0);
      end
      wr(SRXL_OFF_IRQ_MASK, 32'h0);
      wr(SRXL_OFF_SUBCLASS, 32'h0);
      sync_req <= 1'b1;
      ev(8'h0, 8'h0, 8'h0, 1'b1);
      rd(SRXL_OFF_SYNC_STAT, 32'h1, 1'b0);
      wr(SRXL_OFF_SUBCLASS, 32'h1);
      ev(8'h0, 8'h0, 8'h0, 1'b1);
      rd(SRXL_OFF_SYNC_STAT, 32'h10001, 1'b0);
      wr(SRXL_OFF_SYNC_STAT, 32'hffffffff);
      rd(SRXL_OFF_SYNC_STAT, 32'h10001, 1'b0);
      // interrupt: clear, unmask, lose sync, mask, clear
      wr(SRXL_OFF_IRQ_STAT, 32'h7);
      rd(SRXL_OFF_IRQ_STAT, 32'h0, 1'b0);
      wr(SRXL_OFF_IRQ_MASK, 32'h7);
      sync_req <= 1'b0;
      settle(3);
      chk("irq set", 32'h1, {31'h0, irq});
      rd(SRXL_OFF_IRQ_STAT, 32'h4, 1'b0);
      rd(SRXL_OFF_SYNC_STAT, 32'h10000, 1'b0);
      wr(SRXL_OFF_IRQ_MASK, 32'h3);
      settle(1);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(SRXL_OFF_IRQ_STAT, 32'h4);
      wr(SRXL_OFF_IRQ_MASK, 32'h7);
      settle(1);
      chk("irq cleared", 32'h0, {31'h0, irq});
      v = $urandom;
      cgs_req <= v[7:0];
      k_req <= v[15:8];
      ev(8'h0, v[23:16], v[31:24], 1'b0);
      for (i = 0; i < 8; i++) begin
         exd[4*i +: 4] = {v[24+i], v[16+i], v[i], v[8+i]};
      end
      rd(SRXL_OFF_DEBUG, exd, 1'b0);
      for (i = 0; i < 8; i++) exd[4*i+2 +: 2] = 2'b00;
      rd(SRXL_OFF_DEBUG, exd, 1'b0);
      // mid-run reset must clear sticky flags, counters and controls
      ev(8'h0, 8'hff, 8'hff, 1'b0);
      repeat (2) @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd(SRXL_OFF_DEBUG, exd, 1'b0);
      rd(SRXL_OFF_ERR_CTRL, 32'h0, 1'b0);
      rd(SRXL_OFF_ERRCNT_LO, 32'h0, 1'b0);
      wr(8'h5c, 32'hffffffff);
      rd(8'h5c, 32'h0, 1'b1);
      rd(8'h02, 32'h0, 1'b1);
      settle(2);
      chk("notes left", 32'h0, 32'(q.size()));
      results();
   end
endmodule
